/* dv/test_vrt_raster_gen.sv */
// Purpose : Self-checking bench for the raster timing generator.
// Assumes : Shrunk mode, 15 clocks by 8 lines, driven at falling edges.
// Notes   : Colour is compared against the address pattern of the memory model.
`timescale 1ns/100ps
module test_vrt_raster_gen;
  localparam H_VIS   = 8;
  localparam H_FRONT = 2;
  localparam H_PULSE = 3;
  localparam H_BACK  = 2;
  localparam V_VIS   = 4;
  localparam V_FRONT = 1;
  localparam V_PULSE = 2;
  localparam V_BACK  = 1;
  localparam HT = H_VIS + H_FRONT + H_PULSE + H_BACK;
  localparam VT = V_VIS + V_FRONT + V_PULSE + V_BACK;
  logic        sys_clk_in;
  logic        rstn_in;
  logic [11:0] mem_data;
  logic [9:0]  col;
  logic [9:0]  row;
  logic        req;
  logic        hsync_n;
  logic        vsync_n;
  logic [3:0]  r;
  logic [3:0]  g;
  logic [3:0]  b;
  int          miscompares = 0;
  int          n_checks = 0;
  vrt_raster_gen #(.H_VISIBLE(H_VIS), .H_FRONT(H_FRONT), .H_SYNC(H_PULSE),
    .H_BACK(H_BACK), .V_VISIBLE(V_VIS), .V_FRONT(V_FRONT), .V_SYNC(V_PULSE),
    .V_BACK(V_BACK)) i_dut (.sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in), .pixel_data_in(mem_data), .pixel_col_out(col),
    .pixel_row_out(row), .pixel_req_out(req), .red_out(r), .green_out(g),
    .blue_out(b), .horizontal_sync_out(hsync_n), .vertical_sync_out(vsync_n));
  vrt_pixel_mem i_mem (.col_in(col), .row_in(row), .req_in(req), .data_out(mem_data));
  // Pixel clock at 50 MHz.
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  function automatic logic [11:0] pat(logic [9:0] c, logic [9:0] w);
    return {c[3:0], w[3:0], c[3:0] ^ w[3:0]};
  endfunction
  task automatic chk_v(logic [11:0] got, logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(logic [11:0] got, int exp);
    chk_v(got[11:0], exp[11:0]);
  endtask
  task automatic wrap_up;
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset for four clocks: syncs idle high, colour and request low.
  task automatic t_reset;
    rstn_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    chk_v({r, g, b}, 12'h0);
    chk_v({col[5:0], row[2:0], req, hsync_n, vsync_n}, 12'h003);
    rstn_in = 1'b1;
  endtask
  // One whole frame from the origin: syncs, visible count and every colour.
  task automatic t_frame;
    int k;
    logic [11:0] hl;
    logic [11:0] vl;
    logic [11:0] nv;
    logic [9:0] pc;
    logic [9:0] pr;
    logic pq;
    k = 0;
    while (!(col === 10'h0 && row === 10'h0)) begin
      @(negedge sys_clk_in);
      k++;
      if (k > 2 * HT * VT) begin
        miscompares++;
        wrap_up;
      end
    end
    hl = 12'h000;
    vl = 12'h000;
    nv = 12'h000;
    for (int i = 0; i < HT * VT; i++) begin
      {pc, pr, pq} = {col, row, req};
      @(negedge sys_clk_in);
      chk_v({r, g, b}, pq ? pat(pc, pr) : 12'h0);
      hl = hl + {11'h000, !hsync_n};
      vl = vl + {11'h000, !vsync_n};
      nv = nv + {11'h000, req};
    end
    chk_n(hl, VT * H_PULSE);
    chk_n(vl, HT * V_PULSE);
    chk_n(nv, H_VIS * V_VIS);
  endtask
  // Reset mid-frame: counting restarts at the origin.
  task automatic t_midreset;
    repeat (37) @(negedge sys_clk_in);
    t_reset;
    @(negedge sys_clk_in);
    chk_v({col, row[1:0]}, 12'h0);
    @(negedge sys_clk_in);
    chk_v({col, row[1:0]}, 12'h4);
  endtask
  initial begin
    rstn_in = 1'b0;
    t_reset;
    t_frame;
    t_midreset;
    t_frame;
    wrap_up;
  end
endmodule

/* dv/vrt_pixel_mem.sv */
// Purpose : Pixel memory model answering in the cycle after an address.
// Assumes : Combinational read of the registered column and row.
// Notes   : Unselected cycles show the inverse pattern, never stale data.
`timescale 1ns/100ps
module vrt_pixel_mem (
  input  wire logic [9:0]  col_in,
  input  wire logic [9:0]  row_in,
  input  wire logic        req_in,
  output logic      [11:0] data_out
);
  wire [11:0] pat = {col_in[3:0], row_in[3:0], col_in[3:0] ^ row_in[3:0]};
  // Colour is a pure function of the address so any slip shows up.
  assign data_out = req_in ? pat : ~pat;
endmodule

/* dv/vrt_raster_checker.sv */
// Purpose : Port assertions for the raster timing generator.
// Assumes : Parameters match the bound instance.
// Notes   : Checks begin two clocks after reset is released.
`timescale 1ns/100ps
module vrt_raster_checker #(
  parameter H_VISIBLE = 8, H_FRONT = 2, H_SYNC = 3, H_BACK = 2,
  parameter V_VISIBLE = 4, V_FRONT = 1, V_SYNC = 2, V_BACK = 1
) (
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic [11:0] pixel_data_in,
  input wire logic [9:0]  pixel_col_out,
  input wire logic [9:0]  pixel_row_out,
  input wire logic        pixel_req_out,
  input wire logic [3:0]  red_out,
  input wire logic [3:0]  green_out,
  input wire logic [3:0]  blue_out,
  input wire logic        horizontal_sync_out,
  input wire logic        vertical_sync_out
);
  localparam HT = H_VISIBLE + H_FRONT + H_SYNC + H_BACK;
  localparam VT = V_VISIBLE + V_FRONT + V_SYNC + V_BACK;
  localparam H_SYNC_AT = H_VISIBLE + H_FRONT;
  localparam V_SYNC_AT = V_VISIBLE + V_FRONT;
  logic [1:0] up_r;
  logic       hin_r;
  logic       vin_r;
  wire        ok = up_r[1];
  wire        lastc = (pixel_col_out == HT - 1);
  wire [11:0] rgb = {red_out, green_out, blue_out};
  // Start-up count and sync windows, one clock behind column and row.
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      up_r <= 2'h0;
      hin_r <= 1'b0;
      vin_r <= 1'b0;
    end else begin
      up_r <= up_r + {1'b0, !up_r[1]};
      hin_r <= pixel_col_out >= H_SYNC_AT && pixel_col_out < H_SYNC_AT + H_SYNC;
      vin_r <= pixel_row_out >= V_SYNC_AT && pixel_row_out < V_SYNC_AT + V_SYNC;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // The requested colour stands on the outputs one clock after the request.
  sequence s_shown;
    ##1 rgb == $past(pixel_data_in);
  endsequence
  a_col_step: assert property (ok && !lastc |=>
    pixel_col_out == $past(pixel_col_out) + 10'h1) else $error("column step wrong");
  a_col_wrap: assert property (ok && lastc |=> pixel_col_out == 10'h0)
    else $error("column wrap wrong");
  a_row_hold: assert property (ok && !lastc |=> $stable(pixel_row_out))
    else $error("row moved mid-line");
  a_row_step: assert property (ok && lastc |=> pixel_row_out ==
    ($past(pixel_row_out) == VT - 1 ? 10'h0 : $past(pixel_row_out) + 10'h1))
    else $error("row step wrong");
  a_req_area: assert property (ok |-> pixel_req_out ==
    (pixel_col_out < H_VISIBLE && pixel_row_out < V_VISIBLE)) else $error("req wrong");
  a_hsync_window: assert property (ok |-> horizontal_sync_out == !hin_r)
    else $error("horizontal sync wrong");
  a_vsync_window: assert property (ok |-> vertical_sync_out == !vin_r)
    else $error("vertical sync wrong");
  a_blank_zero: assert property (ok && !pixel_req_out |=> rgb == 12'h0)
    else $error("colour outside visible area");
  a_pixel_shown: assert property (ok && pixel_req_out |-> s_shown)
    else $error("pixel colour wrong");
endmodule
bind vrt_raster_gen vrt_raster_checker #(.H_VISIBLE(H_VISIBLE), .H_FRONT(H_FRONT),
  .H_SYNC(H_SYNC), .H_BACK(H_BACK), .V_VISIBLE(V_VISIBLE), .V_FRONT(V_FRONT),
  .V_SYNC(V_SYNC), .V_BACK(V_BACK)) i_chk (.sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in), .pixel_data_in(pixel_data_in), .pixel_col_out(pixel_col_out),
  .pixel_row_out(pixel_row_out), .pixel_req_out(pixel_req_out), .red_out(red_out),
  .green_out(green_out), .blue_out(blue_out),
  .horizontal_sync_out(horizontal_sync_out), .vertical_sync_out(vertical_sync_out));

/* hdl/vrt_counter.v */
// Purpose : Wrapping counter used for both raster axes.
// Assumes : Single clock, asynchronous active-low reset.
// Notes   : Advances only when step_in is high; wraps after TOTAL-1.
`timescale 1ns/100ps

module vrt_counter #(
  parameter WIDTH = 10,
  parameter TOTAL = 800
) (
  input  wire             sys_clk_in,
  input  wire             rstn_in,
  input  wire             step_in,
  output reg  [WIDTH-1:0] count_out,
  output wire             last_out
);

  // The final count is cut down to the counter width on purpose.
  localparam integer     LAST_INT = TOTAL - 1;
  localparam [WIDTH-1:0] LAST_VAL = LAST_INT[WIDTH-1:0];

  // Flags the final count so the caller can chain the next axis.
  assign last_out = (count_out == LAST_VAL);

  // Counts up and wraps to zero at the end of the period.
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_out <= {WIDTH{1'b0}};
    end else if (step_in) begin
      if (last_out) begin
        count_out <= {WIDTH{1'b0}};
      end else begin
        count_out <= count_out + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* hdl/vrt_raster_gen.v */
// Purpose : Raster timing generator for a 640x480 analogue monitor.
// Assumes : sys_clk_in is the pixel clock; pixel memory answers one clock after
//           an address is presented.
// Notes   : Counter origin is the first visible pixel, so column and row are
//           the memory coordinates directly. All outputs are registered.
//           Each axis walks four phases in this order:
//             visible     : colour shown, sync high.
//             front porch : blank, sync high.
//             sync pulse  : blank, sync low.
//             back porch  : blank, sync high, then the axis wraps.
//           The column counter steps every pixel clock; the row counter steps
//           once per line, on the clock in which the column counter wraps.
//           Colour outputs trail the counters by two clocks, one for the address
//           stage and one for the memory answer; syncs are delayed to match.
//           Horizontal and vertical sync edges keep a fixed phase: the
//           frame pulse starts on the clock that shows column zero of its line.
//           In reset, colour is zero, the request is low and both syncs idle
//           high; counting starts at the first visible pixel on release.
`timescale 1ns/100ps
`include "vrt_timing_map.vh"

// Defaults give the 640x480 mode from a 25 MHz clock, just under 60 Hz.
module vrt_raster_gen #(
  parameter H_VISIBLE = `VRT_H_VISIBLE,
  parameter H_FRONT   = `VRT_H_FRONT_PORCH,
  parameter H_SYNC    = `VRT_H_SYNC_PULSE,
  parameter H_BACK    = `VRT_H_BACK_PORCH,
  parameter V_VISIBLE = `VRT_V_VISIBLE,
  parameter V_FRONT   = `VRT_V_FRONT_PORCH,
  parameter V_SYNC    = `VRT_V_SYNC_PULSE,
  parameter V_BACK    = `VRT_V_BACK_PORCH
) (
  input  wire                        sys_clk_in,
  input  wire                        rstn_in,
  input  wire [3*`VRT_COLOUR_W-1:0]  pixel_data_in,
  output reg  [`VRT_H_CNT_W-1:0]     pixel_col_out,
  output reg  [`VRT_V_CNT_W-1:0]     pixel_row_out,
  output reg                         pixel_req_out,
  output reg  [`VRT_COLOUR_W-1:0]    red_out,
  output reg  [`VRT_COLOUR_W-1:0]    green_out,
  output reg  [`VRT_COLOUR_W-1:0]    blue_out,
  output reg                         horizontal_sync_out,
  output reg                         vertical_sync_out
);

  // ****************************************
  // Derived boundaries
  // ****************************************
  // Line and frame lengths in clocks and lines.
  localparam H_TOTAL = H_VISIBLE + H_FRONT + H_SYNC + H_BACK;
  localparam V_TOTAL = V_VISIBLE + V_FRONT + V_SYNC + V_BACK;

  // Phase codes shared by both axes.
  localparam [1:0] PH_VISIBLE     = 2'h0;
  localparam [1:0] PH_FRONT_PORCH = 2'h1;
  localparam [1:0] PH_SYNC_PULSE  = 2'h2;
  localparam [1:0] PH_BACK_PORCH  = 2'h3;

  // Cuts a column boundary down to the counter width on purpose.
  function [`VRT_H_CNT_W-1:0] to_col;
    input integer val;
    begin
      to_col = val[`VRT_H_CNT_W-1:0];
    end
  endfunction

  // Cuts a row boundary down to the counter width on purpose.
  function [`VRT_V_CNT_W-1:0] to_row;
    input integer val;
    begin
      to_row = val[`VRT_V_CNT_W-1:0];
    end
  endfunction

  // Window edges, held at counter width.
  localparam [`VRT_H_CNT_W-1:0] H_VIS_END  = to_col(H_VISIBLE);
  localparam [`VRT_H_CNT_W-1:0] H_SYNC_BEG = to_col(H_VISIBLE + H_FRONT);
  localparam [`VRT_H_CNT_W-1:0] H_SYNC_END = to_col(H_VISIBLE + H_FRONT + H_SYNC);
  localparam [`VRT_V_CNT_W-1:0] V_VIS_END  = to_row(V_VISIBLE);
  localparam [`VRT_V_CNT_W-1:0] V_SYNC_BEG = to_row(V_VISIBLE + V_FRONT);
  localparam [`VRT_V_CNT_W-1:0] V_SYNC_END = to_row(V_VISIBLE + V_FRONT + V_SYNC);

  // Names the phase that pos lies in; the back porch runs up to the wrap.
  function [1:0] phase_of;
    input [9:0] pos;
    input [9:0] vis_end;
    input [9:0] pulse_beg;
    input [9:0] pulse_end;
    begin
      if (pos < vis_end) begin
        phase_of = PH_VISIBLE;
      end else if (pos < pulse_beg) begin
        phase_of = PH_FRONT_PORCH;
      end else if (pos < pulse_end) begin
        phase_of = PH_SYNC_PULSE;
      end else begin
        phase_of = PH_BACK_PORCH;
      end
    end
  endfunction

  // ****************************************
  // Counters
  // ****************************************
  wire [`VRT_H_CNT_W-1:0] h_cnt;
  wire [`VRT_V_CNT_W-1:0] v_cnt;
  wire                    h_last;

  // Pixel counter, one step per pixel clock, free running.
  vrt_counter #(
    .WIDTH (`VRT_H_CNT_W),
    .TOTAL (H_TOTAL)
  ) u_h_cnt (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .step_in    (1'b1),
    .count_out  (h_cnt),
    .last_out   (h_last)
  );

  // Line counter, one step per line, free running.
  vrt_counter #(
    .WIDTH (`VRT_V_CNT_W),
    .TOTAL (V_TOTAL)
  ) u_v_cnt (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .step_in    (h_last),
    .count_out  (v_cnt),
    .last_out   ()
  );

  // ****************************************
  // Timing decode
  // ****************************************
  wire [1:0] h_phase = phase_of(h_cnt, H_VIS_END, H_SYNC_BEG, H_SYNC_END);
  wire [1:0] v_phase = phase_of(v_cnt, V_VIS_END, V_SYNC_BEG, V_SYNC_END);
  wire       in_area = (h_phase == PH_VISIBLE) && (v_phase == PH_VISIBLE);

  // Phase of the pixel now being addressed, and its decoded meaning.
  reg [1:0] h_phase_r;
  reg [1:0] v_phase_r;
  reg       colour_en;
  reg       h_pulse;
  reg       v_pulse;

  // ****************************************
  // Address stage
  // ****************************************
  // Address stage: request the pixel under the counters one clock ahead.
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pixel_col_out <= 10'h000;
      pixel_row_out <= 10'h000;
      pixel_req_out <= 1'b0;
      // Parking both phases in a porch keeps the picture blank, syncs idle.
      h_phase_r     <= PH_FRONT_PORCH;
      v_phase_r     <= PH_FRONT_PORCH;
    end else begin
      pixel_col_out <= h_cnt;
      pixel_row_out <= v_cnt;
      pixel_req_out <= in_area;
      h_phase_r     <= h_phase;
      v_phase_r     <= v_phase;
    end
  end

  // ****************************************
  // Phase decode
  // ****************************************
  // Horizontal phase gates colour and forms the line pulse.
  always @* begin
    colour_en = 1'b0;
    h_pulse   = 1'b0;
    case (h_phase_r)
      PH_VISIBLE: begin
        colour_en = (v_phase_r == PH_VISIBLE);
      end
      PH_SYNC_PULSE: begin
        h_pulse = 1'b1;
      end
      default: begin
        colour_en = 1'b0;
        h_pulse   = 1'b0;
      end
    endcase
  end

  // Vertical phase forms the frame pulse; it covers whole lines.
  always @* begin
    v_pulse = 1'b0;
    case (v_phase_r)
      PH_SYNC_PULSE: begin
        v_pulse = 1'b1;
      end
      default: begin
        v_pulse = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Output stage
  // ****************************************
  // Output stage: colour and sync aligned to the same pixel period.
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      red_out             <= 4'h0;
      green_out           <= 4'h0;
      blue_out            <= 4'h0;
      horizontal_sync_out <= `VRT_SYNC_IDLE;
      vertical_sync_out   <= `VRT_SYNC_IDLE;
    end else begin
      // Twelve colour bits, blanked outside the visible area.
      red_out   <= colour_en ? pixel_data_in[11:8] : 4'h0;
      green_out <= colour_en ? pixel_data_in[7:4]  : 4'h0;
      blue_out  <= colour_en ? pixel_data_in[3:0]  : 4'h0;
      // Sync pulses are active low.
      horizontal_sync_out <= h_pulse ? `VRT_SYNC_ACTIVE : `VRT_SYNC_IDLE;
      vertical_sync_out   <= v_pulse ? `VRT_SYNC_ACTIVE : `VRT_SYNC_IDLE;
    end
  end

endmodule

/* pkg/vrt_timing_map.vh */
// Purpose : Timing constants for the raster timing generator.
// Assumes : One pixel per clock at the rate given by VRT_PIXEL_CLK_HZ.
// Notes   : Counts are in pixel clocks (horizontal) and lines (vertical).
`ifndef VRT_TIMING_MAP_VH
`define VRT_TIMING_MAP_VH

// ****************************************
// Pixel clock
// ****************************************
`define VRT_PIXEL_CLK_HZ   25000000

// ****************************************
// Horizontal timing in pixel clocks
// ****************************************
`define VRT_H_VISIBLE      640
`define VRT_H_FRONT_PORCH  16
`define VRT_H_SYNC_PULSE   96
`define VRT_H_BACK_PORCH   48
`define VRT_H_TOTAL        800

// ****************************************
// Vertical timing in lines
// ****************************************
`define VRT_V_VISIBLE      480
`define VRT_V_FRONT_PORCH  10
`define VRT_V_SYNC_PULSE   2
`define VRT_V_BACK_PORCH   29
`define VRT_V_TOTAL        521

// ****************************************
// Widths and reset values
// ****************************************
`define VRT_H_CNT_W        10
`define VRT_V_CNT_W        10
`define VRT_COLOUR_W       4
`define VRT_SYNC_IDLE      1'b1
`define VRT_SYNC_ACTIVE    1'b0

`endif
